// ==== rtl/asct_core.sv ====
// Serial command timing core of a multichannel delta-sigma converter.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Data output floats 6 to 10 master clocks after last clock edge.
// - Data output floats at once when chip select goes high.
// - Single calibrations take 7 data-ready periods, full one takes 14.
// - Clock-high 300 to 500 then low 5 starts the reset pattern.
// - Second high pulse lasts 550 to 750, then a low as before.
// - Third high pulse 1050 to 1250 completes pattern; device resets.
// - Result update lasts at least 4 master clocks; reads then invalid.
// - Data-ready goes low when a calibration ends.
// - Active-low reset pin resets the whole device.
module asct_core (
    // Core clock, reset and enable
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    // Pins
    input wire logic reset_pin_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    // Data output as two signals, value and active-low enable
    output logic dout_o,
    output logic dout_oe_n,
    // Converter side
    input wire logic conv_tick,
    input wire logic [23:0] conv_result,
    output logic data_ready_n,
    output logic busy,
    output logic device_reset
);
    // ------------------------------------------------------------------
    // Link instance
    // ------------------------------------------------------------------
    logic link_dout;
    logic [7:0] link_rx_byte;
    logic link_rx_toggle;
    logic [23:0] result_ff;

    asct_link u_link (
        .sclk(sclk),
        .cs_n(cs_n),
        .rst(reset),
        .din(din),
        .dout(link_dout),
        .tx_word(result_ff),
        .rx_byte(link_rx_byte),
        .rx_toggle(link_rx_toggle)
    );

    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    localparam int CNT_W_L = asct_pkg::CNT_W;

    typedef struct packed {
        logic [1:0] sclk_sy;
        logic [1:0] cs_sy;
        logic [1:0] rst_sy;
        logic [1:0] dout_sy;
        logic [2:0] tog_sy;
        logic sclk_d;
        logic [CNT_W_L-1:0] rel_cnt;
        logic releasing;
        logic oe_n;
        logic dout;
        asct_pkg::asct_srst_type sr;
        logic [CNT_W_L-1:0] sr_cnt;
        asct_pkg::asct_cal_type cal;
        logic [3:0] cal_left;
        logic [CNT_W_L-1:0] busy_cnt;
        logic [2:0] upd_cnt;
        logic data_ready_n_n;
        logic dev_rst;
        logic [23:0] result;
        logic busy;
    } asct_core_state_type;

    asct_core_state_type st_ff;
    asct_core_state_type nxt_st;

    // Saturating increment used by the release and reset-pattern counters.
    function automatic logic [CNT_W_L-1:0] sat_inc(
        input logic [CNT_W_L-1:0] v
    );
        sat_inc = (&v) ? v : v + 1'b1;
    endfunction

    // Checks that a counted width lies inside a window.
    function automatic logic in_win(
        input logic [CNT_W_L-1:0] v,
        input int lo,
        input int hi
    );
        in_win = (int'(v) >= lo) && (int'(v) <= hi);
    endfunction

    logic sclk_s, cs_n_s, rx_event;
    logic rise, fall;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        // Two-flop synchronisers, three for the toggle; only the last stage (last two for the toggle) is used below.
        nxt_st.sclk_sy = {st_ff.sclk_sy[0], sclk};
        nxt_st.cs_sy = {st_ff.cs_sy[0], cs_n};
        nxt_st.rst_sy = {st_ff.rst_sy[0], reset_pin_n};
        nxt_st.dout_sy = {st_ff.dout_sy[0], link_dout};
        nxt_st.tog_sy = {st_ff.tog_sy[1:0], link_rx_toggle};
        nxt_st.sclk_d = sclk_s;
        nxt_st.dev_rst = 1'b0;

        // Data output drive; floats immediately on select high.
        if (cs_n_s) begin
            nxt_st.oe_n = 1'b1;
            nxt_st.releasing = 1'b0;
        end else if (rise || fall) begin
            nxt_st.oe_n = 1'b0;
            nxt_st.releasing = 1'b1;
            nxt_st.rel_cnt = '0;
        end else if (st_ff.releasing) begin
            // Release after a fixed count inside the 6..10 window.
            nxt_st.rel_cnt = sat_inc(st_ff.rel_cnt);
            // The synchroniser delay is taken off the count.
            if (int'(st_ff.rel_cnt) ==
                asct_pkg::DOUT_REL_CYC - asct_pkg::SYNC_LAT - 1) begin
                nxt_st.oe_n = 1'b1;
                nxt_st.releasing = 1'b0;
            end
        end
        nxt_st.dout = st_ff.dout_sy[1];

        // Result update window blocks a new word for 4 clocks.
        if (st_ff.upd_cnt != 3'd0) begin
            nxt_st.upd_cnt = st_ff.upd_cnt - 3'd1;
            if (st_ff.upd_cnt == 3'd1) begin
                nxt_st.data_ready_n_n = 1'b0;
            end
        end else if (conv_tick && cs_n_s && st_ff.cal == asct_pkg::CAL_IDLE) begin
            nxt_st.result = conv_result;
            nxt_st.upd_cnt = 3'(asct_pkg::UPDATE_MIN);
            nxt_st.data_ready_n_n = 1'b1;
        end

        // Calibration counts data-ready periods, then flags ready.
        case (st_ff.cal)
            asct_pkg::CAL_IDLE: begin
            end
            asct_pkg::CAL_RUN: begin
                nxt_st.data_ready_n_n = 1'b1;
                if (conv_tick) begin
                    nxt_st.cal_left = st_ff.cal_left - 4'd1;
                    if (st_ff.cal_left == 4'd1) begin
                        nxt_st.cal = asct_pkg::CAL_DONE;
                    end
                end
            end
            asct_pkg::CAL_DONE: begin
                nxt_st.data_ready_n_n = 1'b0;
                nxt_st.cal = asct_pkg::CAL_IDLE;
            end
            default: nxt_st.cal = asct_pkg::CAL_IDLE;
        endcase

        // Decode bytes taken from the link.
        if (rx_event && st_ff.cal == asct_pkg::CAL_IDLE) begin
            case (link_rx_byte)
                asct_pkg::CMD_SELF_FULL_CAL: begin
                    nxt_st.cal = asct_pkg::CAL_RUN;
                    nxt_st.cal_left = 4'(asct_pkg::CAL_FULL_DR);
                end
                asct_pkg::CMD_SELF_OFFSET_CAL,
                asct_pkg::CMD_SELF_GAIN_CAL,
                asct_pkg::CMD_SYS_OFFSET_CAL,
                asct_pkg::CMD_SYS_GAIN_CAL: begin
                    nxt_st.cal = asct_pkg::CAL_RUN;
                    nxt_st.cal_left = 4'(asct_pkg::CAL_SINGLE_DR);
                end
                asct_pkg::CMD_RESET: nxt_st.dev_rst = 1'b1;
                default: begin
                end
            endcase
        end

        // Serial-clock reset pattern recogniser.
        case (st_ff.sr)
            asct_pkg::SR_IDLE: begin
                nxt_st.sr_cnt = '0;
                if (rise) nxt_st.sr = asct_pkg::SR_HI1;
            end
            asct_pkg::SR_HI1, asct_pkg::SR_HI2, asct_pkg::SR_HI3: begin
                nxt_st.sr_cnt = sat_inc(st_ff.sr_cnt);
                if (fall) begin
                    nxt_st.sr_cnt = '0;
                    if (st_ff.sr == asct_pkg::SR_HI1 &&
                        in_win(st_ff.sr_cnt, asct_pkg::SRST_P1_MIN - 1,
                               asct_pkg::SRST_P1_MAX - 1)) begin
                        nxt_st.sr = asct_pkg::SR_LO1;
                    end else if (st_ff.sr == asct_pkg::SR_HI2 &&
                        in_win(st_ff.sr_cnt, asct_pkg::SRST_P2_MIN - 1,
                               asct_pkg::SRST_P2_MAX - 1)) begin
                        nxt_st.sr = asct_pkg::SR_LO2;
                    end else if (st_ff.sr == asct_pkg::SR_HI3 &&
                        in_win(st_ff.sr_cnt, asct_pkg::SRST_P3_MIN - 1,
                               asct_pkg::SRST_P3_MAX - 1)) begin
                        nxt_st.dev_rst = 1'b1;
                        nxt_st.sr = asct_pkg::SR_IDLE;
                    end else begin
                        nxt_st.sr = asct_pkg::SR_IDLE;
                    end
                end
            end
            asct_pkg::SR_LO1, asct_pkg::SR_LO2: begin
                nxt_st.sr_cnt = sat_inc(st_ff.sr_cnt);
                if (rise) begin
                    nxt_st.sr_cnt = '0;
                    // A too-short low breaks the pattern.
                    if (int'(st_ff.sr_cnt) < asct_pkg::SRST_LOW_MIN - 1) begin
                        nxt_st.sr = asct_pkg::SR_HI1;
                    end else if (st_ff.sr == asct_pkg::SR_LO1) begin
                        nxt_st.sr = asct_pkg::SR_HI2;
                    end else begin
                        nxt_st.sr = asct_pkg::SR_HI3;
                    end
                end
            end
            default: nxt_st.sr = asct_pkg::SR_IDLE;
        endcase

        // Busy window after a reset, exposed to the converter side.
        if (st_ff.busy_cnt != '0) begin
            nxt_st.busy_cnt = st_ff.busy_cnt - 1'b1;
        end

        // Any reset source clears the block state.
        if (nxt_st.dev_rst || !st_ff.rst_sy[1]) begin
            nxt_st.cal = asct_pkg::CAL_IDLE;
            nxt_st.sr = asct_pkg::SR_IDLE;
            nxt_st.data_ready_n_n = 1'b1;
            nxt_st.upd_cnt = 3'd0;
            nxt_st.result = 24'h0000_00;
            nxt_st.dev_rst = 1'b1;
            nxt_st.busy_cnt = CNT_W_L'(asct_pkg::RESET_BUSY);
        end
        nxt_st.busy = (nxt_st.busy_cnt != '0);
    end

    assign sclk_s = st_ff.sclk_sy[1];
    assign cs_n_s = st_ff.cs_sy[1];
    assign rise = sclk_s && !st_ff.sclk_d;
    assign fall = !sclk_s && st_ff.sclk_d;
    assign rx_event = st_ff.tog_sy[2] ^ st_ff.tog_sy[1];

    // ------------------------------------------------------------------
    // Register stage
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_ff <= '0;
            st_ff.rst_sy <= 2'b11;
            st_ff.cs_sy <= 2'b11;
            st_ff.oe_n <= 1'b1;
            st_ff.data_ready_n_n <= 1'b1;
            st_ff.sr <= asct_pkg::SR_IDLE;
            st_ff.cal <= asct_pkg::CAL_IDLE;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    assign result_ff = st_ff.result;
    assign dout_o = st_ff.dout;
    assign dout_oe_n = st_ff.oe_n;
    assign data_ready_n = st_ff.data_ready_n_n;
    assign busy = st_ff.busy;
    assign device_reset = st_ff.dev_rst;
endmodule : asct_core
`default_nettype wire

// ==== rtl/asct_pkg.sv ====
// Constants for the converter serial command timing block.
package asct_pkg;
    // ------------------------------------------------------------------
    // Clock and timing figures
    // ------------------------------------------------------------------
    localparam int CORE_CLK_NS = 25;
    // Master clock periods counted in core_clk cycles (master clock = core).
    localparam int DOUT_REL_MIN = 6;
    localparam int DOUT_REL_MAX = 10;
    localparam int DOUT_REL_CYC = 8;
    // Core cycles from a link clock edge to its detection by the core.
    localparam int SYNC_LAT = 3;
    localparam int SRST_P1_MIN = 300;
    localparam int SRST_P1_MAX = 500;
    localparam int SRST_LOW_MIN = 5;
    localparam int SRST_P2_MIN = 550;
    localparam int SRST_P2_MAX = 750;
    localparam int SRST_P3_MIN = 1050;
    localparam int SRST_P3_MAX = 1250;
    localparam int UPDATE_MIN = 4;
    localparam int CAL_SINGLE_DR = 7;
    localparam int CAL_FULL_DR = 14;
    localparam int RESET_BUSY = 2640;
    localparam int CNT_W = 12;
    localparam int DR_W = 4;
    // ------------------------------------------------------------------
    // Command codes of this block (one byte each)
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_SELF_OFFSET_CAL = 8'hF1;
    localparam logic [7:0] CMD_SELF_GAIN_CAL = 8'hF2;
    localparam logic [7:0] CMD_SELF_FULL_CAL = 8'hF0;
    localparam logic [7:0] CMD_SYS_OFFSET_CAL = 8'hF3;
    localparam logic [7:0] CMD_SYS_GAIN_CAL = 8'hF4;
    localparam logic [7:0] CMD_RESET = 8'hFE;
    localparam logic [7:0] CMD_READ_DATA = 8'h01;

    typedef enum logic [2:0] {
        SR_IDLE, SR_HI1, SR_LO1, SR_HI2, SR_LO2, SR_HI3
    } asct_srst_type;

    typedef enum logic [1:0] {
        CAL_IDLE, CAL_RUN, CAL_DONE
    } asct_cal_type;
endpackage : asct_pkg

// ==== rtl/asct_link.sv ====
// Link-side shifter running on the serial clock domain.
`timescale 1ns/1ps
`default_nettype none
module asct_link (
    // Link clock, select and block reset
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic rst,
    // Serial data
    input wire logic din,
    output logic dout,
    // Core side
    input wire logic [23:0] tx_word,
    output logic [7:0] rx_byte,
    output logic rx_toggle
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] bit_cnt;
        logic [7:0] shift;
        logic [23:0] tx_shift;
        logic first;
    } asct_link_state_type;

    // Byte events kept apart: they must outlive chip select.
    typedef struct packed {
        logic [7:0] rx_byte;
        logic rx_toggle;
    } asct_link_event_type;

    asct_link_state_type st_ff;
    asct_link_state_type nxt_st;
    asct_link_event_type ev_ff;
    asct_link_event_type nxt_ev;

    // Input sampled on rising edge; chip select high restarts the frame.
    always_comb begin
        nxt_st = st_ff;
        nxt_ev = ev_ff;
        nxt_st.shift = {st_ff.shift[6:0], din};
        nxt_st.bit_cnt = st_ff.bit_cnt + 3'd1;
        if (st_ff.first) begin
            nxt_st.tx_shift = tx_word;
            nxt_st.first = 1'b0;
        end else begin
            nxt_st.tx_shift = {st_ff.tx_shift[22:0], 1'b0};
        end
        if (st_ff.bit_cnt == 3'd7) begin
            nxt_ev.rx_byte = {st_ff.shift[6:0], din};
            nxt_ev.rx_toggle = ~ev_ff.rx_toggle;
        end
    end

    // Frame state cleared asynchronously by chip select going high.
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            st_ff.bit_cnt <= 3'd0;
            st_ff.shift <= 8'h00;
            st_ff.tx_shift <= 24'h0000_00;
            st_ff.first <= 1'b1;
        end else begin
            st_ff.bit_cnt <= nxt_st.bit_cnt;
            st_ff.shift <= nxt_st.shift;
            st_ff.tx_shift <= nxt_st.tx_shift;
            st_ff.first <= nxt_st.first;
        end
    end

    // The event toggle survives chip select so no byte is lost; the
    // block reset clears it together with the core's synchroniser.
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            ev_ff <= '0;
        end else begin
            ev_ff <= nxt_ev;
        end
    end

    assign rx_byte = ev_ff.rx_byte;
    assign rx_toggle = ev_ff.rx_toggle;
    assign dout = st_ff.first ? tx_word[23] : st_ff.tx_shift[23];
endmodule : asct_link
`default_nettype wire

// ==== tb/asct_core_properties.sv ====
// Checker of the serial command timing core as seen at its ports.
`timescale 1ns/1ps
`default_nettype none
module asct_core_properties (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Watched pins
    input wire logic reset_pin_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic conv_tick,
    input wire logic dout_oe_n,
    input wire logic data_ready_n,
    input wire logic busy,
    input wire logic device_reset
);
    logic sclk_ff;
    logic [11:0] idle_ff;
    logic [11:0] busy_ff;
    logic [11:0] tick_ff;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // Saturating counts: quiet link clock, busy run length, tick age.
    always_ff @(posedge core_clk) begin
        sclk_ff <= sclk;
        if (reset || sclk != sclk_ff) idle_ff <= '0;
        else if (idle_ff != 12'hfff) idle_ff <= idle_ff + 12'd1;
        if (reset || !busy) busy_ff <= '0;
        else if (busy_ff != 12'hfff) busy_ff <= busy_ff + 12'd1;
        if (reset || conv_tick) tick_ff <= '0;
        else if (tick_ff != 12'hfff) tick_ff <= tick_ff + 12'd1;
    end
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    property p_cs_release;
        $rose(cs_n) |-> ##[0:12] dout_oe_n;
    endproperty
    a_cs_release: assert property (p_cs_release)
        else $error("output still driven after deselect");
    property p_cs_held;
        cs_n [*6] |-> dout_oe_n;
    endproperty
    a_cs_held: assert property (p_cs_held)
        else $error("output driven while deselected");
    property p_idle_release;
        idle_ff >= 12'd16 |-> dout_oe_n;
    endproperty
    a_idle_release: assert property (p_idle_release)
        else $error("output not floated after the last clock edge");
    property p_early_release;
        $rose(dout_oe_n) && !cs_n && !$past(reset) |-> idle_ff >= 12'd6;
    endproperty
    a_early_release: assert property (p_early_release)
        else $error("output floated too soon after a clock edge");
    property p_pin_reset;
        $fell(reset_pin_n) |-> ##[1:6] device_reset;
    endproperty
    a_pin_reset: assert property (p_pin_reset)
        else $error("reset pin gave no device reset");
    property p_busy_after;
        device_reset |=> busy [*8];
    endproperty
    a_busy_after: assert property (p_busy_after)
        else $error("busy not raised after device reset");
    property p_busy_len;
        $fell(busy) && !$past(reset) |->
            busy_ff >= 12'd2638 && busy_ff <= 12'd2642;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy period of wrong length");
    property p_ready_update;
        $fell(data_ready_n) |-> $past(data_ready_n, 2)
            && $past(data_ready_n, 3) && $past(data_ready_n, 4);
    endproperty
    a_ready_update: assert property (p_ready_update)
        else $error("update period shorter than four cycles");
    property p_ready_cause;
        $fell(data_ready_n) |-> tick_ff <= 12'd16;
    endproperty
    a_ready_cause: assert property (p_ready_cause)
        else $error("data ready fell with no recent tick");
endmodule // asct_core_properties
bind asct_core asct_core_properties u_props (.core_clk, .reset,
    .reset_pin_n, .sclk, .cs_n, .conv_tick, .dout_oe_n, .data_ready_n,
    .busy, .device_reset);
`default_nettype wire

// ==== tb/asct_host.sv ====
// Host model that drives the serial command pins of the converter.
`timescale 1ns/1ps
`default_nettype none
module asct_host (
    // Serial pins driven by the host
    output logic sclk,
    output logic cs_n,
    output logic din
);
    localparam int HALF = 24;
    localparam int OSC = 25;
    // The link clock stands still low between frames.
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b1;
    end
    // One byte MSB first; select stays low until deselect is called.
    task automatic send_byte(input logic [7:0] b);
        cs_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            #HALF din = b[i];
            sclk = 1'b0;
            #HALF sclk = 1'b1;
        end
        #HALF sclk = 1'b0;
        din = ~b[0]; // A stale bit would hide a missed sample.
    endtask
    // Ends the frame; the bench keeps the gaps before the next command.
    // No command with a longer gap is issued.
    task automatic deselect();
        cs_n = 1'b1;
    endtask
    // Three long clock-high pulses, each followed by a short low.
    task automatic clk_pattern(input int h1, input int h2, input int h3);
        cs_n = 1'b0;
        #(OSC * 8) sclk = 1'b1;
        #(OSC * h1) sclk = 1'b0;
        #(OSC * 10) sclk = 1'b1;
        #(OSC * h2) sclk = 1'b0;
        #(OSC * 10) sclk = 1'b1;
        #(OSC * h3) sclk = 1'b0;
        #(OSC * 10) cs_n = 1'b1;
    endtask
endmodule // asct_host
`default_nettype wire

// ==== tb/test_adc_serial_command_timing.sv ====
// Self-checking bench for the serial command timing core.
`timescale 1ns/1ps
`default_nettype none
module test_adc_serial_command_timing;
    typedef struct {
        logic [7:0] cmd;
        int h1;
        int h2;
        int h3;
        logic want;
    } asct_row_type;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic reset_pin_n = 1'b1;
    logic conv_tick = 1'b0;
    logic [23:0] conv_result = 24'h00_0000;
    logic sclk, cs_n, din, dout_o, dout_oe_n;
    logic data_ready_n, busy, device_reset;
    logic rst_seen = 1'b0;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n;
    // Zero command marks a clock-pattern row; h1 is otherwise a tick count.
    asct_row_type rows [9] = '{
        '{8'h00, 310, 560, 1060, 1'b1}, '{8'h00, 250, 600, 1100, 1'b0},
        '{8'h00, 400, 450, 1100, 1'b0}, '{8'h00, 400, 600, 1350, 1'b0},
        '{8'h00, 490, 740, 1240, 1'b1},
        '{asct_pkg::CMD_SELF_OFFSET_CAL, 7, 0, 0, 1'b0},
        '{asct_pkg::CMD_SELF_GAIN_CAL, 7, 0, 0, 1'b0},
        '{asct_pkg::CMD_SYS_OFFSET_CAL, 7, 0, 0, 1'b0},
        '{asct_pkg::CMD_SYS_GAIN_CAL, 7, 0, 0, 1'b0}};
    asct_core DUT (.core_clk(core_clk), .reset(reset), .clk_en(1'b1),
        .reset_pin_n(reset_pin_n), .sclk(sclk), .cs_n(cs_n), .din(din),
        .dout_o(dout_o), .dout_oe_n(dout_oe_n), .conv_tick(conv_tick),
        .conv_result(conv_result), .data_ready_n(data_ready_n),
        .busy(busy), .device_reset(device_reset));
    asct_host u_host (.sclk(sclk), .cs_n(cs_n), .din(din));
    // Master clock and a cycle ceiling that cuts a hang short.
    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (device_reset === 1'b1) rst_seen <= 1'b1;
        if (cyc == 80000) begin
            error_cnt++;
            final_report();
        end
    end
    task automatic check(input logic seen, input logic exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task automatic cycles(input int k);
        repeat (k) @(negedge core_clk);
    endtask
    // Bounded wait for the end of the busy time after a reset.
    task automatic wait_idle();
        n = 0;
        while (busy !== 1'b0 && n < 3000) begin
            cycles(1);
            n++;
        end
    endtask
    // Runs a calibration with a fixed tick count; data ready is checked high before the last tick and low after it.
    task automatic run_cal(input logic [7:0] cmd, input int ticks);
        reset = 1'b1;
        cycles(1);
        reset = 1'b0;
        cycles(1);
        u_host.send_byte(cmd);
        u_host.deselect();
        for (int k = 1; k <= ticks; k++) begin
            cycles(12);
            conv_tick = 1'b1;
            conv_result = conv_result + 24'h01_0101;
            cycles(1);
            conv_tick = 1'b0;
            if (k == ticks - 1) check(data_ready_n, 1'b1);
        end
        cycles(12);
        check(data_ready_n, 1'b0);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        cycles(4);
        check(dout_oe_n, 1'b1);
        check(data_ready_n, 1'b1);
        check(busy, 1'b0);
        check(device_reset, 1'b0);
        reset = 1'b0;
        cycles(2);
        foreach (rows[i]) begin
            rst_seen = 1'b0;
            if (rows[i].cmd == 8'h00) begin
                u_host.clk_pattern(rows[i].h1, rows[i].h2, rows[i].h3);
                cycles(20);
                check(rst_seen, rows[i].want);
                wait_idle();
            end else begin
                run_cal(rows[i].cmd, rows[i].h1);
            end
        end
        // The combined calibration takes twice as long.
        run_cal(asct_pkg::CMD_SELF_FULL_CAL, 14);
        // Reset pin, then the length of the busy time.
        rst_seen = 1'b0;
        reset_pin_n = 1'b0;
        cycles(3);
        reset_pin_n = 1'b1;
        cycles(8);
        check(rst_seen, 1'b1);
        wait_idle();
        check(n > 2620 && n <= 2640, 1'b1);
        // Reset by command.
        rst_seen = 1'b0;
        u_host.send_byte(asct_pkg::CMD_RESET);
        u_host.deselect();
        cycles(10);
        check(rst_seen, 1'b1);
        cycles(20);
        wait_idle();
        // A fresh result, then its update window on data ready.
        conv_result = 24'h01_0000;
        conv_tick = 1'b1;
        cycles(1);
        conv_tick = 1'b0;
        cycles(2);
        check(data_ready_n, 1'b1);
        cycles(3);
        check(data_ready_n, 1'b0);
        // Read frame: word shifted from frame start, bit 16 after a byte.
        u_host.send_byte(asct_pkg::CMD_READ_DATA);
        cycles(10);
        check(dout_o, 1'b1);
        cycles(41);
        u_host.send_byte(8'h00);
        cycles(5);
        check(dout_oe_n, 1'b0);
        cycles(6);
        check(dout_oe_n, 1'b1);
        // Deselect right after the last edge floats the output at once.
        cycles(4);
        u_host.send_byte(8'h00);
        u_host.deselect();
        cycles(4);
        check(dout_oe_n, 1'b1);
        cycles(10);
        final_report();
    end
endmodule // test_adc_serial_command_timing
`default_nettype wire
